// *** hw/dsw_pkg.sv ***
// package for the deep sleep wake status block
// Contract
// RQ1: bit 7 pin-bank wakeup flag goes 1 when pin bank woke chip from deep sleep.
// RQ2: bit 4 timebase wakeup flag goes 1 when time base 0 interrupt woke chip.
// RQ3: bits 6 and 5 are unimplemented and always read zero.
// RQ4: bit 3 core 3V power-on-reset flag set by hardware on 3V domain power-on reset.
// RQ5: core 3V flag cleared by software writing zero or by watchdog-clear instruction.
// RQ6: software sets the pin wakeup mask before deep sleep.
// RQ7: software sets time base 0 control and its flag before deep sleep.
// RQ8: implemented bits read back; writing zero clears the two wakeup flags.
// RQ9: halt with deep-sleep arm bit set enters deep sleep.
// RQ10: pin-bank falling edge or time base 0 interrupt wakes; restart at 0000h.
// RQ11: time base 0 wakeup works whether or not its interrupt is enabled.
// RQ12: software sets isolation before sleep and clears it after wakeup.
package dsw_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  DSW_OFF_PWC     = 8'h00;
   localparam logic [7:0]  DSW_OFF_IRQ_ST  = 8'h04;
   localparam logic [7:0]  DSW_OFF_IRQ_EN  = 8'h08;
   localparam logic [7:0]  DSW_OFF_IRQ_CLR = 8'h0C;
   localparam logic [7:0]  DSW_OFF_STATE   = 8'h10;

   localparam int DSW_B_PIN  = 7;
   localparam int DSW_B_TB   = 4;
   localparam int DSW_B_POR  = 3;
   localparam int DSW_B_LDO  = 2;
   localparam int DSW_B_ISO  = 1;
   localparam int DSW_B_ARM  = 0;

   localparam logic [7:0]  DSW_PWC_RESET   = 8'h08;
   localparam logic [7:0]  DSW_PWC_MASK    = 8'h9F;
   localparam logic [15:0] DSW_RESTART_PC  = 16'h0000;

   // interrupt events: 0 pin wake, 1 timebase wake, 2 sleep entry
   localparam int DSW_NIRQ = 3;

   localparam logic [1:0]  DSW_RESP_OK     = 2'h0;
   localparam logic [1:0]  DSW_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      DSW_RUN   = 2'h1,
      DSW_SLEEP = 2'h2
   } dsw_mode_t;

   typedef struct packed {
      logic       ldo_low_current_sel;
      logic       io_iso_en;
      logic       deep_sleep_arm;
      logic       deep_sleep;
      logic [15:0] restart_pc;
      logic       restart;
   } dsw_pwr_t;

   typedef struct packed {
      logic       halt_instr;
      logic       watchdog_clear_instr;
      logic       core3v_por;
      logic       pin_bank_fall;
      logic       timebase_irq;
   } dsw_evt_t;

endpackage : dsw_pkg

// *** hw/dsw_irq.sv ***
// sticky status, enable and clear for the block's interrupt
`timescale 1ns/10ps
module dsw_irq import dsw_pkg::*; #(
   parameter int N = DSW_NIRQ
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [N-1:0] evt,
   input  wire logic [N-1:0] clr,
   input  wire logic         en_we,
   input  wire logic [N-1:0] en_wdata,
   output      logic [N-1:0] status,
   output      logic [N-1:0] enable,
   output      logic         irq
);

   typedef struct packed {
      logic [N-1:0] st;
      logic [N-1:0] en;
      logic         irq;
   } dsw_irq_st_t;

   dsw_irq_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      // set wins over clear
      s_d.st = (s_q.st & ~clr) | evt;
      if (en_we) begin
         s_d.en = en_wdata;
      end
      s_d.irq = |(s_d.st & s_d.en);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign status = s_q.st;
   assign enable = s_q.en;
   assign irq    = s_q.irq;

   a_irq_level : assert property (@(posedge aclk) disable iff (!aresetn)
      irq == |(status & enable)) else $error("irq level wrong");
   a_irq_sticky : assert property (@(posedge aclk) disable iff (!aresetn)
      |evt |=> |status) else $error("event not latched");

endmodule // dsw_irq

// *** hw/dsw_top.sv ***
// power and wake control register with AXI4-Lite access
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module dsw_top import dsw_pkg::*; (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire dsw_evt_t    evt,
   output      dsw_pwr_t    pwr,
   output      logic        irq
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  aw_addr;
      logic        aw_have;
      logic [31:0] w_data;
      logic        w_strb0;
      logic        w_have;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [7:0]  pwc;
      dsw_mode_t   mode;
      logic        restart;
      logic        pin_q;
      logic        tb_q;
   } dsw_st_t;

   dsw_st_t q, d;

   logic [DSW_NIRQ-1:0] irq_evt, irq_clr, irq_st, irq_en;
   logic                irq_en_we;
   logic                wr_go, rd_go, pin_edge, tb_edge, wake_pin, wake_tb, enter;

   function automatic logic [31:0] rd_mux(input logic [7:0] a, input dsw_st_t s,
                                          input logic [DSW_NIRQ-1:0] st,
                                          input logic [DSW_NIRQ-1:0] en);
      case (a)
         // unimplemented bits read zero
         DSW_OFF_PWC:    rd_mux = {24'h000000, s.pwc & DSW_PWC_MASK};
         DSW_OFF_IRQ_ST: rd_mux = {29'h00000000, st};
         DSW_OFF_IRQ_EN: rd_mux = {29'h00000000, en};
         DSW_OFF_STATE:  rd_mux = {30'h00000000, s.mode};
         default:        rd_mux = 32'h00000000;
      endcase
   endfunction

   function automatic logic known(input logic [7:0] a);
      known = (a == DSW_OFF_PWC) || (a == DSW_OFF_IRQ_ST) || (a == DSW_OFF_IRQ_EN) ||
              (a == DSW_OFF_IRQ_CLR) || (a == DSW_OFF_STATE);
   endfunction

   assign wr_go    = q.aw_have && q.w_have && !q.bvalid;
   assign rd_go    = s_axi_arvalid && !q.rvalid;
   assign pin_edge = q.pin_q && !evt.pin_bank_fall ? 1'b0 : (evt.pin_bank_fall && !q.pin_q);
   assign tb_edge  = evt.timebase_irq && !q.tb_q;
   // wake only from deep sleep; interrupt enable not consulted
   assign wake_pin = (q.mode == DSW_SLEEP) && pin_edge;
   // RQ11: tb wake, enable ignored
   assign wake_tb  = (q.mode == DSW_SLEEP) && tb_edge && !wake_pin;
   assign enter    = (q.mode == DSW_RUN) && evt.halt_instr && q.pwc[DSW_B_ARM];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      d.pin_q   = evt.pin_bank_fall;
      d.tb_q    = evt.timebase_irq;
      d.restart = 1'b0;
      if (s_axi_awvalid && !q.aw_have) begin
         d.aw_have = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_have) begin
         d.w_have  = 1'b1;
         d.w_data  = s_axi_wdata;
         d.w_strb0 = s_axi_wstrb[0];
      end
      if (wr_go) begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = known(q.aw_addr) ? DSW_RESP_OK : DSW_RESP_SLVERR;
         // RQ8: software write, readback
         if (q.aw_addr == DSW_OFF_PWC && q.w_strb0) begin
            d.pwc = q.w_data[7:0] & DSW_PWC_MASK;
         end
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (rd_go) begin
         d.rvalid = 1'b1;
         d.rresp  = known(s_axi_araddr) ? DSW_RESP_OK : DSW_RESP_SLVERR;
         d.rdata  = rd_mux(s_axi_araddr, q, irq_st, irq_en);
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      // RQ5: watchdog clear drops por flag
      if (evt.watchdog_clear_instr) begin
         d.pwc[DSW_B_POR] = 1'b0;
      end
      // RQ4: hardware set wins
      if (evt.core3v_por) begin
         d.pwc[DSW_B_POR] = 1'b1;
      end
      // RQ9: halt with arm enters sleep
      if (enter) begin
         d.mode = DSW_SLEEP;
      end
      // RQ10: wake and restart
      if (wake_pin || wake_tb) begin
         d.mode    = DSW_RUN;
         d.restart = 1'b1;
      end
      // RQ1: pin bank wake flag
      if (wake_pin) begin
         d.pwc[DSW_B_PIN] = 1'b1;
      end
      // RQ2: timebase wake flag
      if (wake_tb) begin
         d.pwc[DSW_B_TB] = 1'b1;
      end
      // RQ3: reserved bits forced zero
      d.pwc = d.pwc & DSW_PWC_MASK;
      case (d.mode)
         DSW_RUN, DSW_SLEEP: d.mode = d.mode;
         default:            d.mode = DSW_RUN;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q      <= '0;
         q.pwc  <= DSW_PWC_RESET;
         q.mode <= DSW_RUN;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   assign irq_evt   = {enter, wake_tb, wake_pin};
   assign irq_clr   = (wr_go && q.aw_addr == DSW_OFF_IRQ_CLR) ? q.w_data[DSW_NIRQ-1:0] : '0;
   assign irq_en_we = wr_go && q.aw_addr == DSW_OFF_IRQ_EN;

   dsw_irq #(.N(DSW_NIRQ)) u_irq (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .evt      (irq_evt),
      .clr      (irq_clr),
      .en_we    (irq_en_we),
      .en_wdata (q.w_data[DSW_NIRQ-1:0]),
      .status   (irq_st),
      .enable   (irq_en),
      .irq      (irq)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = !q.aw_have;
   assign s_axi_wready  = !q.w_have;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rresp   = q.rresp;
   assign s_axi_rdata   = q.rdata;
   assign pwr.ldo_low_current_sel = q.pwc[DSW_B_LDO];
   assign pwr.io_iso_en           = q.pwc[DSW_B_ISO];
   assign pwr.deep_sleep_arm      = q.pwc[DSW_B_ARM];
   assign pwr.deep_sleep          = (q.mode == DSW_SLEEP);
   assign pwr.restart_pc          = DSW_RESTART_PC;
   assign pwr.restart             = q.restart;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_pin_flag_set : assert property (@(posedge aclk) disable iff (!aresetn) // RQ1
      wake_pin |=> q.pwc[DSW_B_PIN]) else $error("pin wake flag not set");
   a_tb_flag_set : assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
      wake_tb |=> q.pwc[DSW_B_TB]) else $error("timebase wake flag not set");
   a_reserved_zero : assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
      q.pwc[6:5] == 2'h0) else $error("reserved bits nonzero");
   a_por_flag_set : assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
      evt.core3v_por |=> q.pwc[DSW_B_POR]) else $error("por flag not set");
   a_por_wdt_clear : assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
      evt.watchdog_clear_instr && !evt.core3v_por |=> !q.pwc[DSW_B_POR]) else $error("por not cleared");
   a_pwc_readback : assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
      rd_go && s_axi_araddr == DSW_OFF_PWC |=> s_axi_rdata[7:0] == $past(q.pwc)) else $error("readback wrong");
   a_sleep_entry : assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
      enter |=> pwr.deep_sleep) else $error("sleep not entered");
   a_wake_restart : assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
      (wake_pin || wake_tb) |=> pwr.restart && !pwr.deep_sleep ##1 !pwr.restart) else $error("wake restart wrong");
   a_tb_no_enable : assert property (@(posedge aclk) disable iff (!aresetn) // RQ11
      pwr.deep_sleep && tb_edge |=> !pwr.deep_sleep) else $error("timebase did not wake");

   c_sleep_pin : cover property (@(posedge aclk) disable iff (!aresetn) enter ##[1:50] wake_pin);
   c_sleep_tb : cover property (@(posedge aclk) disable iff (!aresetn) enter ##[1:50] wake_tb);
   c_irq : cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));

endmodule // dsw_top

// *** bench/tb.sv ***
// self-checking bench for the power and wake control block
`timescale 1ns/10ps
module tb import dsw_pkg::*;;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd_v;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp, resp_v;
   dsw_evt_t    evt = '0;
   dsw_pwr_t    pwr;
   int          failures = 0;
   int          compares = 0;
   typedef struct packed { logic [31:0] wd; logic [31:0] exp; } dsw_row_t;
   dsw_row_t    rows [5] = '{'{32'hFF, 32'h9F}, '{32'h60, 32'h00}, '{32'h16, 32'h16},
                             '{32'h88, 32'h88}, '{32'h00, 32'h00}};

   always #12.5 aclk = ~aclk;

   dsw_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt(evt), .pwr(pwr),
      .irq(irq));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      if (failures == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tk;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = awready & awvalid; tw = wready & wvalid; tk = bvalid; resp_v = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = arready & arvalid; tr = rvalid; rd_v = rdata; resp_v = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end while (!tr);
      rready <= 1'b0;
   endtask

   // one-cycle event level, checked just after the edge that samples it
   task automatic ev(input int k);
      @(posedge aclk);
      evt[k] <= 1'b1;
      @(posedge aclk);
      evt <= '0;
      #1;
   endtask

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(DSW_OFF_PWC);
      chk(rd_v, 32'h08); // por flag set at reset
      rd(8'h20);
      chk({30'h0, resp_v}, {30'h0, DSW_RESP_SLVERR});
      foreach (rows[i]) begin
         wr(DSW_OFF_PWC, rows[i].wd);
         chk({30'h0, resp_v}, {30'h0, DSW_RESP_OK});
         rd(DSW_OFF_PWC);
         chk(rd_v, rows[i].exp);
         chk({29'h0, pwr.ldo_low_current_sel, pwr.io_iso_en, pwr.deep_sleep_arm}, {29'h0, rows[i].exp[2:0]});
      end
      wr(DSW_OFF_IRQ_EN, 32'h7);
      wr(DSW_OFF_PWC, 32'h03);
      ev(4);
      chk({31'h0, pwr.deep_sleep}, 32'h1);
      rd(DSW_OFF_STATE);
      chk(rd_v, 32'h2);
      chk({31'h0, irq}, 32'h1);
      ev(1);
      chk({pwr.restart_pc, 14'h0, pwr.restart, pwr.deep_sleep}, 32'h2);
      @(posedge aclk); #1;
      chk({31'h0, pwr.restart}, 32'h0);
      rd(DSW_OFF_PWC);
      chk(rd_v & 32'h90, 32'h80);
      wr(DSW_OFF_PWC, 32'h01);
      rd(DSW_OFF_PWC);
      chk(rd_v & 32'h90, 32'h00);
      wr(DSW_OFF_PWC, 32'h03);
      ev(4);
      ev(0);
      chk({31'h0, pwr.deep_sleep}, 32'h0);
      rd(DSW_OFF_PWC);
      chk(rd_v & 32'h90, 32'h10);
      rd(DSW_OFF_IRQ_ST);
      chk(rd_v, 32'h7);
      wr(DSW_OFF_IRQ_CLR, 32'h7);
      rd(DSW_OFF_IRQ_ST);
      chk(rd_v, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rd(DSW_OFF_IRQ_CLR);
      chk(rd_v, 32'h0);
      wr(DSW_OFF_IRQ_EN, 32'h0);
      wr(DSW_OFF_PWC, 32'h03);
      ev(4);
      rd(DSW_OFF_IRQ_ST);
      chk(rd_v, 32'h4);
      chk({31'h0, irq}, 32'h0);
      ev(0);
      chk({31'h0, pwr.deep_sleep}, 32'h0);
      ev(2);
      rd(DSW_OFF_PWC);
      chk(rd_v & 32'h08, 32'h08);
      ev(3);
      rd(DSW_OFF_PWC);
      chk(rd_v & 32'h08, 32'h00);
      // refused byte lane leaves the register alone
      wstrb <= 4'hE;
      wr(DSW_OFF_PWC, 32'h00);
      wstrb <= 4'hF;
      rd(DSW_OFF_PWC);
      chk(rd_v, 32'h13);
      wr(8'h20, 32'hFF);
      chk({30'h0, resp_v}, {30'h0, DSW_RESP_SLVERR});
      // hardware set beats watchdog clear in one cycle
      @(posedge aclk);
      evt <= 5'h0C;
      @(posedge aclk);
      evt <= '0;
      rd(DSW_OFF_PWC);
      chk(rd_v & 32'h08, 32'h08);
      // reset in mid-run, while asleep
      wr(DSW_OFF_IRQ_EN, 32'h7);
      ev(4);
      chk({30'h0, irq, pwr.deep_sleep}, 32'h3);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      chk({29'h0, irq, pwr.deep_sleep, pwr.restart}, 32'h0);
      rd(DSW_OFF_PWC);
      chk(rd_v, 32'h08);
      rd(DSW_OFF_IRQ_EN);
      chk(rd_v, 32'h0);
      conclude();
   end

   initial begin
      #200000;
      failures++;
      conclude();
   end
endmodule // tb
